// File: spm_modem_pins.sv
// Operation
// - carrier-detect low means carrier; readable status
// - ring-indicate low means ring; readable status
// - clear-to-send low means modem accepts data
// - set-ready low means modem ready; readable status
// - control bit 0 drives terminal-ready low
// - control bit 1 drives request-send low
// - master reset or loop: both high
// - after master reset transmit idles marking
// - port-2 infrared mode holds transmit marking
// - bus reset: six pins are strap inputs
// - serial transmit data drives transmit pin
// - receive pin feeds serial receive data
`timescale 1ns/10ps
`default_nettype none
`include "spm_params.svh"
module spm_modem_pins (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        host_bus_reset_n,
    input  wire logic        master_reset_port1,
    input  wire logic        master_reset_port2,
    input  wire logic        loop_mode_port1,
    input  wire logic        loop_mode_port2,
    input  wire logic        infrared_mode_port2,
    input  wire logic [1:0]  modem_control_reg_port1,
    input  wire logic [1:0]  modem_control_reg_port2,
    input  wire logic        tx_data_port1,
    input  wire logic        tx_data_port2,
    input  wire logic        tx_active_port1,
    input  wire logic        tx_active_port2,
    input  wire logic        carrier_detect_in_port1,
    input  wire logic        carrier_detect_in_port2,
    input  wire logic        ring_indicate_in_port1,
    input  wire logic        ring_indicate_in_port2,
    input  wire logic        clear_to_send_in_port1,
    input  wire logic        clear_to_send_in_port2,
    input  wire logic        set_ready_in_port1,
    input  wire logic        set_ready_in_port2,
    input  wire logic        serial_rx_port1,
    input  wire logic        serial_rx_port2,
    input  wire logic        terminal_ready_in_port1,
    input  wire logic        terminal_ready_in_port2,
    input  wire logic        request_send_in_port1,
    input  wire logic        request_send_in_port2,
    input  wire logic        serial_tx_in_port1,
    input  wire logic        serial_tx_in_port2,
    output logic             terminal_ready_out_port1,
    output logic             terminal_ready_out_port2,
    output logic             request_send_out_port1,
    output logic             request_send_out_port2,
    output logic             serial_tx_port1,
    output logic             serial_tx_port2,
    output logic             pin_oe_n,
    output logic [3:0]       modem_status_reg_port1,
    output logic [3:0]       modem_status_reg_port2,
    output logic             rx_data_port1,
    output logic             rx_data_port2,
    output logic [6:1]       strap_option,
    output logic             strap_valid
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [15:0] raw_in;
    logic [15:0] syn_in;
    // strap pins share the same stages so their levels line up with the bus reset release
    assign raw_in = {
        serial_tx_in_port2,
        request_send_in_port2,
        terminal_ready_in_port2,
        serial_tx_in_port1,
        request_send_in_port1,
        terminal_ready_in_port1,
        serial_rx_port2,
        serial_rx_port1,
        carrier_detect_in_port2,
        ring_indicate_in_port2,
        set_ready_in_port2,
        clear_to_send_in_port2,
        carrier_detect_in_port1,
        ring_indicate_in_port1,
        set_ready_in_port1,
        clear_to_send_in_port1
    };

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_sync
            spm_sync u_sync (
                .ref_clk  (ref_clk),
                .sys_rst  (sys_rst),
                .clk_en   (clk_en),
                .rst_val  (1'b1),
                .async_in (raw_in[gi]),
                .sync_out (syn_in[gi])
            );
        end
    endgenerate

    logic bus_rst_sync;
    spm_sync u_brst (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .rst_val  (1'b1),
        .async_in (~host_bus_reset_n),
        .sync_out (bus_rst_sync)
    );

    // ----------------------------------------
    // strap capture state machine
    // ----------------------------------------
    spm_pkg::spm_state_e state;
    spm_pkg::spm_state_e next_state;
    logic                drive_en;

    always_comb begin
        case (state)
            spm_pkg::SPM_ST_STRAP: next_state = bus_rst_sync ? spm_pkg::SPM_ST_STRAP : spm_pkg::SPM_ST_RUN;
            spm_pkg::SPM_ST_RUN:   next_state = bus_rst_sync ? spm_pkg::SPM_ST_STRAP : spm_pkg::SPM_ST_RUN;
            default:               next_state = spm_pkg::SPM_ST_STRAP;
        endcase
    end

    // pins float as inputs while the bus reset holds; straps latched on the release edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state        <= spm_pkg::SPM_ST_STRAP;
            strap_option <= `SPM_STRAP_RST;
            strap_valid  <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            if (state == spm_pkg::SPM_ST_STRAP && !bus_rst_sync) begin
                strap_option <= {syn_in[14], syn_in[15], syn_in[13],
                                 syn_in[12], syn_in[11], syn_in[10]};
                strap_valid  <= 1'b1;
            end else if (state == spm_pkg::SPM_ST_STRAP) begin
                strap_valid  <= 1'b0;
            end
        end
    end
    assign drive_en = (state == spm_pkg::SPM_ST_RUN);
    assign pin_oe_n = ~drive_en;

    // ----------------------------------------
    // modem status and receive data
    // ----------------------------------------
    // status bits are active high views of the active-low pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            modem_status_reg_port1 <= `SPM_MSR_RST;
            modem_status_reg_port2 <= `SPM_MSR_RST;
            rx_data_port1          <= 1'b1;
            rx_data_port2          <= 1'b1;
        end else if (clk_en) begin
            modem_status_reg_port1 <= ~syn_in[3:0];
            modem_status_reg_port2 <= ~syn_in[7:4];
            rx_data_port1          <= syn_in[8];
            rx_data_port2          <= syn_in[9];
        end
    end

    // ----------------------------------------
    // modem control and transmit outputs
    // ----------------------------------------
    wire hold1 = master_reset_port1 | loop_mode_port1;
    wire hold2 = master_reset_port2 | loop_mode_port2;
    logic mr_idle1;
    logic mr_idle2;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            terminal_ready_out_port1 <= 1'b1;
            terminal_ready_out_port2 <= 1'b1;
            request_send_out_port1   <= 1'b1;
            request_send_out_port2   <= 1'b1;
            serial_tx_port1          <= 1'b1;
            serial_tx_port2          <= 1'b1;
            mr_idle1                 <= 1'b1;
            mr_idle2                 <= 1'b1;
        end else if (clk_en) begin
            // marking holds from master reset until a frame starts
            mr_idle1 <= master_reset_port1 | (mr_idle1 & ~tx_active_port1);
            mr_idle2 <= master_reset_port2 | (mr_idle2 & ~tx_active_port2);
            terminal_ready_out_port1 <= hold1 | ~modem_control_reg_port1[`SPM_MCR_DTR];
            request_send_out_port1   <= hold1 | ~modem_control_reg_port1[`SPM_MCR_RTS];
            terminal_ready_out_port2 <= hold2 | ~modem_control_reg_port2[`SPM_MCR_DTR];
            request_send_out_port2   <= hold2 | ~modem_control_reg_port2[`SPM_MCR_RTS];
            serial_tx_port1 <= master_reset_port1 | (mr_idle1 & ~tx_active_port1) | tx_data_port1;
            serial_tx_port2 <= master_reset_port2 | infrared_mode_port2
                               | (mr_idle2 & ~tx_active_port2) | tx_data_port2;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_LOOP_DTR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && loop_mode_port1 |=> terminal_ready_out_port1)
        else $error("terminal ready low in loop mode");
    AST_LOOP_RTS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && loop_mode_port2 |=> request_send_out_port2)
        else $error("request send low in loop mode");
    AST_DTR_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !hold1 && modem_control_reg_port1[`SPM_MCR_DTR] |=> !terminal_ready_out_port1)
        else $error("terminal ready not driven low");
    AST_RTS_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !hold2 && modem_control_reg_port2[`SPM_MCR_RTS] |=> !request_send_out_port2)
        else $error("request send not driven low");
    AST_MR_MARK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && master_reset_port1 |=> serial_tx_port1)
        else $error("transmit not marking after master reset");
    AST_IR_MARK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && infrared_mode_port2 |=> serial_tx_port2)
        else $error("transmit not marking in infrared mode");
    AST_STRAP_FLOAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == spm_pkg::SPM_ST_STRAP |-> pin_oe_n)
        else $error("pins driven during bus reset");
    sequence seq_strap_release;
        clk_en && state == spm_pkg::SPM_ST_STRAP && !bus_rst_sync;
    endsequence
    sequence seq_drive_captured;
        strap_valid && !pin_oe_n;
    endsequence
    AST_STRAP_CAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_strap_release |=> seq_drive_captured)
        else $error("straps not captured on release");
    AST_STRAP_CLR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && state == spm_pkg::SPM_ST_STRAP && bus_rst_sync |=> !strap_valid)
        else $error("stale straps still valid during bus reset");

    // control outputs of the other port and master reset defaults
    AST_LOOP_TERMINAL_READY_OUT_PORT2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && loop_mode_port2 |=> terminal_ready_out_port2)
        else $error("terminal ready 2 low in loop mode");
    AST_LOOP_REQUEST_SEND_OUT_PORT1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && loop_mode_port1 |=> request_send_out_port1)
        else $error("request send 1 low in loop mode");
    AST_MR_CTL1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && master_reset_port1 |=> terminal_ready_out_port1 && request_send_out_port1)
        else $error("port 1 control low after master reset");
    AST_MR_CTL2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && master_reset_port2 |=> terminal_ready_out_port2 && request_send_out_port2)
        else $error("port 2 control low after master reset");
    AST_TERMINAL_READY_OUT_PORT2_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !hold2 && modem_control_reg_port2[`SPM_MCR_DTR] |=> !terminal_ready_out_port2)
        else $error("terminal ready 2 not driven low");
    AST_REQUEST_SEND_OUT_PORT1_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !hold1 && modem_control_reg_port1[`SPM_MCR_RTS] |=> !request_send_out_port1)
        else $error("request send 1 not driven low");

    // transmit line
    AST_MR_MARK2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && master_reset_port2 |=> serial_tx_port2)
        else $error("transmit 2 not marking after master reset");
    AST_TX_DATA1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !master_reset_port1 && !mr_idle1 |=> serial_tx_port1 == $past(tx_data_port1))
        else $error("transmit 1 data mismatch");
    AST_TX_DATA2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && !master_reset_port2 && !infrared_mode_port2 && !mr_idle2
        |=> serial_tx_port2 == $past(tx_data_port2))
        else $error("transmit 2 data mismatch");

    // modem status views, one per pin
    AST_MSR_CD2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port2[`SPM_MSR_DCD] == !$past(syn_in[7]))
        else $error("carrier 2 status mismatch");
    AST_MSR_RI1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port1[`SPM_MSR_RI] == !$past(syn_in[2]))
        else $error("ring 1 status mismatch");
    AST_MSR_RI2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port2[`SPM_MSR_RI] == !$past(syn_in[6]))
        else $error("ring 2 status mismatch");
    AST_MSR_CLEAR_TO_SEND_IN_PORT1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port1[`SPM_MSR_CTS] == !$past(syn_in[0]))
        else $error("clear to send 1 status mismatch");
    AST_MSR_CLEAR_TO_SEND_IN_PORT2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port2[`SPM_MSR_CTS] == !$past(syn_in[4]))
        else $error("clear to send 2 status mismatch");
    AST_MSR_SET_READY_IN_PORT1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port1[`SPM_MSR_DSR] == !$past(syn_in[1]))
        else $error("set ready 1 status mismatch");
    AST_MSR_SET_READY_IN_PORT2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port2[`SPM_MSR_DSR] == !$past(syn_in[5]))
        else $error("set ready 2 status mismatch");

    // receive path and port 1 carrier status
    AST_RX_PASS1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> rx_data_port1 == $past(syn_in[8]))
        else $error("receive 1 data mismatch");
    AST_MSR_CD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> modem_status_reg_port1[`SPM_MSR_DCD] == !$past(syn_in[3]))
        else $error("carrier status mismatch");
    AST_RX_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> rx_data_port2 == $past(syn_in[9]))
        else $error("receive data mismatch");
endmodule : spm_modem_pins
`default_nettype wire

// File: spm_params.svh
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH
// ----------------------------------------
// modem status / control bit positions
// ----------------------------------------
`define SPM_MSR_CTS      0
`define SPM_MSR_DSR      1
`define SPM_MSR_RI       2
`define SPM_MSR_DCD      3
`define SPM_MCR_DTR      0
`define SPM_MCR_RTS      1
`define SPM_MSR_RST      4'h0
`define SPM_MCR_RST      2'h0
`define SPM_STRAP_RST    6'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define SPM_CLK_NS       50
`define SPM_SYNC_STAGES  3
`endif

// File: spm_pkg.sv
package spm_pkg;
    typedef enum logic [2:0] {
        SPM_ST_STRAP = 3'b001,
        SPM_ST_RUN   = 3'b010,
        SPM_ST_IDLE  = 3'b100
    } spm_state_e;
    typedef logic [3:0] spm_status_t;
endpackage : spm_pkg

// File: spm_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// three-stage input synchroniser
// ----------------------------------------
module spm_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic rst_val,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic s1;
    logic s2;
    logic s3;

    // stage one only feeds stage two; a change counts once two and three agree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            sync_out <= 1'b1;
        end else if (clk_en) begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_out <= s3;
            end
        end
    end
    // rst_val kept for symmetry of instantiation; reset level is idle high
    logic unused_rst_val;
    assign unused_rst_val = rst_val;
endmodule : spm_sync
`default_nettype wire

// File: spm_modem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far-side modem: status lines, receive line, strap resistors
// ----------------------------------------
module spm_modem_model (
    input  wire logic       ref_clk,
    input  wire logic [9:0] line_req,
    input  wire logic [6:1] strap_req,
    input  wire logic       pin_oe_n,
    input  wire logic [6:1] pin_drv,
    output var  logic [9:0] line,
    output wire logic [6:1] pin_lvl
);
    initial line = 10'h3FF;
    // lines move just after an edge, so the capture stages never see a race
    always @(posedge ref_clk) line <= #1 line_req;
    // the strap resistors show only while the device floats the shared pins
    assign pin_lvl = pin_oe_n ? strap_req : pin_drv;
endmodule : spm_modem_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, (ex), (got)); end end
module tb_top;
    // ----------------------------------------
    // stimulus, wires and model state
    // ----------------------------------------
    logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, host_bus_reset_n = 1'b0;
    logic master_reset_port1 = 1'b0, master_reset_port2 = 1'b0, loop_mode_port1 = 1'b0, loop_mode_port2 = 1'b0;
    logic infrared_mode_port2 = 1'b0, tx_data_port1 = 1'b1, tx_data_port2 = 1'b1;
    logic tx_active_port1 = 1'b0, tx_active_port2 = 1'b0;
    logic [1:0]  modem_control_reg_port1 = 2'h0, modem_control_reg_port2 = 2'h0;
    logic [9:0]  line_req = 10'h3FF;
    logic [6:1]  strap_req = 6'h3F;
    logic [31:0] seed = 32'h0000002A;
    wire logic [9:0] line;
    wire logic [6:1] pin_lvl, strap_option;
    wire logic [3:0] modem_status_reg_port1, modem_status_reg_port2;
    wire logic terminal_ready_out_port1, terminal_ready_out_port2, request_send_out_port1, request_send_out_port2;
    wire logic serial_tx_port1, serial_tx_port2, pin_oe_n, rx_data_port1, rx_data_port2, strap_valid;
    // 2 means the transmit marking hold is not yet known
    int bad_count = 0, n_tests = 0, held1 = 2, held2 = 2;

    spm_modem_pins dut_u (
        .ref_clk, .sys_rst, .clk_en, .host_bus_reset_n, .master_reset_port1, .master_reset_port2,
        .loop_mode_port1, .loop_mode_port2, .infrared_mode_port2, .modem_control_reg_port1,
        .modem_control_reg_port2, .tx_data_port1, .tx_data_port2, .tx_active_port1, .tx_active_port2,
        .clear_to_send_in_port1(line[0]), .set_ready_in_port1(line[1]), .ring_indicate_in_port1(line[2]),
        .carrier_detect_in_port1(line[3]), .serial_rx_port1(line[4]), .clear_to_send_in_port2(line[5]),
        .set_ready_in_port2(line[6]), .ring_indicate_in_port2(line[7]), .carrier_detect_in_port2(line[8]),
        .serial_rx_port2(line[9]), .terminal_ready_in_port1(pin_lvl[1]), .request_send_in_port1(pin_lvl[2]),
        .serial_tx_in_port1(pin_lvl[3]), .terminal_ready_in_port2(pin_lvl[4]), .serial_tx_in_port2(pin_lvl[5]),
        .request_send_in_port2(pin_lvl[6]), .terminal_ready_out_port1, .terminal_ready_out_port2,
        .request_send_out_port1, .request_send_out_port2, .serial_tx_port1, .serial_tx_port2, .pin_oe_n,
        .modem_status_reg_port1, .modem_status_reg_port2, .rx_data_port1, .rx_data_port2, .strap_option, .strap_valid
    );
    spm_modem_model far_u (
        .ref_clk, .line_req, .strap_req, .pin_oe_n, .line, .pin_lvl,
        .pin_drv({request_send_out_port2, serial_tx_port2, terminal_ready_out_port2,
                  serial_tx_port1, request_send_out_port1, terminal_ready_out_port1})
    );

    always #25 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // bus reset with random straps, second one lands mid-run
    // ----------------------------------------
    task automatic strap_phase();
        logic [31:0] r;
        r = xs();
        tick(1);
        host_bus_reset_n = 1'b0;
        strap_req = r[5:0];
        tick(6);
        `CHK("oe_n_strap", 1'b1, pin_oe_n)
        `CHK("strap_valid_low", 1'b0, strap_valid)
        host_bus_reset_n = 1'b1;
        tick(10);
        `CHK("strap_valid", 1'b1, strap_valid)
        `CHK("straps", strap_req, strap_option)
        `CHK("oe_n_run", 1'b0, pin_oe_n)
    endtask : strap_phase

    // ----------------------------------------
    // one random control and line change, then every result
    // ----------------------------------------
    task automatic step();
        logic [31:0] r;
        r = xs();
        tick(1);
        master_reset_port1 = (r[3:0] == 4'h0);
        master_reset_port2 = (r[7:4] == 4'h0);
        loop_mode_port1 = r[8] & r[9];
        loop_mode_port2 = r[10] & r[11];
        infrared_mode_port2 = r[12];
        modem_control_reg_port1 = r[14:13];
        modem_control_reg_port2 = r[16:15];
        tx_data_port1 = r[17];
        tx_data_port2 = r[18];
        line_req = r[29:20];
        // active drops each step so a later rise can end the marking hold
        tx_active_port1 = 1'b0;
        tx_active_port2 = 1'b0;
        if (master_reset_port1) held1 = 1;
        if (master_reset_port2) held2 = 1;
        tick(1);
        `CHK("terminal_ready_out_port1", master_reset_port1 | loop_mode_port1 | ~modem_control_reg_port1[0], terminal_ready_out_port1)
        `CHK("request_send_out_port1", master_reset_port1 | loop_mode_port1 | ~modem_control_reg_port1[1], request_send_out_port1)
        `CHK("terminal_ready_out_port2", master_reset_port2 | loop_mode_port2 | ~modem_control_reg_port2[0], terminal_ready_out_port2)
        `CHK("request_send_out_port2", master_reset_port2 | loop_mode_port2 | ~modem_control_reg_port2[1], request_send_out_port2)
        tx_active_port1 = r[30] & ~master_reset_port1;
        tx_active_port2 = r[31] & ~master_reset_port2;
        if (tx_active_port1) held1 = 0;
        if (tx_active_port2) held2 = 0;
        tick(8);
        if (held1 != 2) `CHK("tx1", (held1 == 1) ? 1'b1 : tx_data_port1, serial_tx_port1)
        if (held2 != 2 || infrared_mode_port2)
            `CHK("tx2", (held2 == 1 || infrared_mode_port2) ? 1'b1 : tx_data_port2, serial_tx_port2)
        `CHK("status1", ~line_req[3:0], modem_status_reg_port1)
        `CHK("status2", ~line_req[8:5], modem_status_reg_port2)
        `CHK("rx1", line_req[4], rx_data_port1)
        `CHK("rx2", line_req[9], rx_data_port2)
    endtask : step

    initial begin
        tick(16);
        sys_rst = 1'b0;
        strap_phase();
        for (int i = 0; i < 60; i++) step();
        strap_phase();
        for (int i = 0; i < 30; i++) step();
        results();
    end

    initial begin
        #250000;
        bad_count++;
        results();
    end
endmodule : tb_top
`default_nettype wire
